// file: nfd_pkg.sv
/*
  Constants, enumerations and carrier structs for the node fault diagnosis block.
  Assumes one clock and a synchronous reset; all event inputs are synchronous to it.
*/
package nfd_pkg;
  localparam int NSAME = 4;
  localparam int NOPP = 3;
  localparam int NTOT = NSAME + NOPP;
  localparam int IDXW = 3;
  localparam int CNTW = 4;
  localparam logic [IDXW-1:0] OPP_BASE = 3'h4;
  localparam logic [IDXW-1:0] NODE_LIMIT = 3'h7;

  typedef enum logic [2:0] {
    NFD_SELFTEST = 3'b000,
    NFD_DETECT = 3'b001,
    NFD_INIT = 3'b010,
    NFD_JOIN = 3'b011,
    NFD_PRESERVE = 3'b100
  } nfd_mode_type;

  typedef enum logic [1:0] {
    NFD_EV_NONE = 2'b00,
    NFD_EV_SINGLE = 2'b01,
    NFD_EV_SUSP = 2'b10,
    NFD_EV_UNEXPECTED = 2'b11
  } nfd_evkind_type;

  typedef struct packed {
    nfd_evkind_type kind;
    logic [IDXW-1:0] node;
    logic [1:0] row;
    logic [1:0] col;
  } nfd_error_type;

  typedef struct packed {
    logic procStart;
    logic procEnd;
    logic expectsInput;
    logic peCommEnd;
    logic localEnd;
    logic collectiveEnd;
  } nfd_timing_type;

  typedef struct packed {
    logic localFail;
    logic cliqueFail;
    logic noClique;
  } nfd_fault_type;

  typedef logic [NTOT-1:0][NTOT-1:0] nfd_ballot_type;

  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_ACC = 5'h08;
  localparam logic [4:0] REG_CONV = 5'h0C;
  localparam logic [4:0] REG_TRUST = 5'h10;
  localparam logic [4:0] REG_SUSP = 5'h14;
  localparam int CTRL_ACK_BIT = 8;
  localparam logic [1:0] SELF_IDX_RESET = 2'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// file: nfd_diag.sv
/*
  Diagnostic state of one bus node: suspicions, accusations, convictions, trust,
  clique validity and failure triggers, with an Avalon-MM register slave.
  Assumes the protocol engine drives process and interval strobes synchronously.
*/
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module nfd_diag (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire nfd_pkg::nfd_mode_type mode,
  input wire nfd_pkg::nfd_error_type errEvent,
  input wire nfd_pkg::nfd_timing_type timing,
  input wire nfd_pkg::nfd_fault_type fault,
  input wire nfd_pkg::nfd_ballot_type voterAcc,
  input wire logic [nfd_pkg::NTOT-1:0] voterOk,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [nfd_pkg::NTOT-1:0] trusted,
  output logic [nfd_pkg::NTOT-1:0] accused,
  output logic [nfd_pkg::NTOT-1:0] convicted,
  output logic cliqueValid,
  output logic selfTestReq,
  output logic abandon
);
  import nfd_pkg::*;

  logic [NSAME-1:0][NOPP-1:0] susp;
  logic [NSAME-1:0][NOPP-1:0] next_susp;
  logic [NTOT-1:0] acc, next_acc, conv, next_conv;
  logic [NTOT-1:0] pendDuring, pendBetween, next_pendDuring, next_pendBetween;
  logic [NTOT-1:0] trust, eventAcc, newDuring, newBetween, suspAcc, convVote;
  logic inProcess, duringHit, modeEntry, selfAcc, cliqueBad;
  logic failLocal, failClique, failNone, failStop;
  logic hitLocal, hitClique, hitNone, hitStop, anyHit;
  logic [1:0] selfIdx;
  nfd_mode_type prevMode;
  logic busAccept;

  function automatic logic majority(input logic [NTOT-1:0] bits,
                                    input logic [NTOT-1:0] elig);
    logic [CNTW-1:0] yes;
    logic [CNTW-1:0] all;
    yes = '0;
    all = '0;
    for (int k = 0; k < NTOT; k++) begin
      yes = yes + CNTW'(bits[k] & elig[k]);
      all = all + CNTW'(elig[k]);
    end
    return {yes, 1'b0} > {1'b0, all};
  endfunction

  assign trust = ~(acc | conv);

  // Self-test takes nothing from the bus, so no event reaches the matrices
  always_comb begin
    eventAcc = '0;
    if (mode != NFD_SELFTEST) begin
      if (errEvent.kind == NFD_EV_SINGLE && errEvent.node < NODE_LIMIT) begin
        eventAcc[errEvent.node] = 1'b1;
      end
      if (errEvent.kind == NFD_EV_UNEXPECTED && errEvent.col < 2'(NOPP)) begin
        eventAcc[OPP_BASE + IDXW'(errEvent.col)] = 1'b1;
      end
    end
  end

  // An event seen in the start or end cycle of a process belongs to it
  assign duringHit = inProcess | timing.procStart;
  assign newDuring = duringHit ? eventAcc : '0;
  assign newBetween = duringHit ? '0 : eventAcc;

  genvar g;
  for (g = 0; g < NTOT; g++) begin : g_vote
    logic [NTOT-1:0] suspBits;
    logic [NTOT-1:0] suspElig;
    logic [NTOT-1:0] ballot;
    if (g < NSAME) begin : g_same
      always_comb begin
        suspBits = '0;
        suspElig = '0;
        for (int c = 0; c < NOPP; c++) begin
          suspBits[c] = susp[g][c];
          suspElig[c] = trust[NSAME + c];
        end
      end
    end else begin : g_opp
      always_comb begin
        suspBits = '0;
        suspElig = '0;
        for (int r = 0; r < NSAME; r++) begin
          suspBits[r] = susp[r][g - NSAME];
          suspElig[r] = trust[r];
        end
      end
    end
    always_comb begin
      ballot = '0;
      for (int v = 0; v < NTOT; v++) begin
        ballot[v] = voterAcc[v][g];
      end
    end
    assign suspAcc[g] = majority(suspBits, suspElig);
    assign convVote[g] = majority(ballot, trust & voterOk);
  end

  always_comb begin
    next_acc = timing.localEnd ? '0 : acc;
    next_pendDuring = pendDuring | newDuring;
    next_pendBetween = pendBetween | newBetween;
    if (timing.procEnd) begin
      next_acc = next_acc | pendDuring | newDuring;
      next_pendDuring = '0;
    end
    if (timing.procStart && timing.expectsInput) begin
      next_acc = next_acc | pendBetween;
      next_pendBetween = newBetween;
    end
    if (timing.peCommEnd) begin
      next_acc = next_acc | suspAcc;
    end
  end

  always_comb begin
    next_susp = timing.localEnd ? '0 : susp;
    if (mode != NFD_SELFTEST && errEvent.kind == NFD_EV_SUSP &&
        errEvent.col < 2'(NOPP)) begin
      next_susp[errEvent.row][errEvent.col] = 1'b1;
    end
  end

  assign modeEntry = (mode != prevMode) && (mode == NFD_DETECT || mode == NFD_INIT);

  always_comb begin
    next_conv = conv;
    if (timing.collectiveEnd) begin
      next_conv = convVote;
    end else if (modeEntry) begin
      next_conv = '0;
    end
  end

  assign selfAcc = acc[selfIdx];
  assign cliqueBad = ~|trust[NSAME-1:0] | ~|trust[NTOT-1:NSAME] | fault.cliqueFail;

  always_comb begin
    hitLocal = 1'b0;
    hitClique = 1'b0;
    hitNone = 1'b0;
    hitStop = 1'b0;
    case (mode)
      NFD_SELFTEST: begin
        hitLocal = fault.localFail | fault.cliqueFail |
                   (errEvent.kind != NFD_EV_NONE);
      end
      NFD_DETECT: begin
        // Without seeing its own output the node can only blame itself by self-accusation
        hitLocal = selfAcc;
        hitClique = cliqueBad | fault.localFail;
        hitNone = fault.noClique;
      end
      NFD_INIT, NFD_JOIN, NFD_PRESERVE: begin
        hitStop = fault.localFail | cliqueBad | selfAcc;
      end
      default: begin
        hitStop = fault.localFail | fault.cliqueFail;
      end
    endcase
  end

  assign anyHit = hitLocal | hitClique | hitNone | hitStop;
  assign busAccept = (avs_read | avs_write) & ~avs_waitrequest;

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= '0;
      pendDuring <= '0;
      pendBetween <= '0;
    end else if (ce) begin
      acc <= next_acc;
      pendDuring <= next_pendDuring;
      pendBetween <= next_pendBetween;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      susp <= '0;
    end else if (ce) begin
      susp <= next_susp;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      conv <= '0;
      prevMode <= NFD_SELFTEST;
      inProcess <= 1'b0;
    end else if (ce) begin
      conv <= next_conv;
      prevMode <= mode;
      if (timing.procEnd) begin
        inProcess <= 1'b0;
      end else if (timing.procStart) begin
        inProcess <= 1'b1;
      end
    end
  end

  // Sticky failure flags; a new failure in the acknowledge cycle survives it
  always_ff @(posedge clk) begin
    if (reset) begin
      failLocal <= 1'b0;
      failClique <= 1'b0;
      failNone <= 1'b0;
      failStop <= 1'b0;
      selfTestReq <= 1'b0;
      abandon <= 1'b0;
    end else if (ce) begin
      if (busAccept && avs_write && avs_address == REG_CTRL &&
          avs_writedata[CTRL_ACK_BIT]) begin
        failLocal <= hitLocal;
        failClique <= hitClique;
        failNone <= hitNone;
        failStop <= hitStop;
        selfTestReq <= anyHit && mode != NFD_SELFTEST;
      end else begin
        failLocal <= failLocal | hitLocal;
        failClique <= failClique | hitClique;
        failNone <= failNone | hitNone;
        failStop <= failStop | hitStop;
        selfTestReq <= selfTestReq | (anyHit && mode != NFD_SELFTEST);
      end
      abandon <= anyHit && mode != NFD_SELFTEST;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trusted <= '1;
      accused <= '0;
      convicted <= '0;
      cliqueValid <= 1'b1;
    end else if (ce) begin
      trusted <= ~(next_acc | next_conv);
      accused <= next_acc;
      convicted <= next_conv;
      cliqueValid <= (|(~(next_acc[NSAME-1:0] | next_conv[NSAME-1:0]))) &&
                     (|(~(next_acc[NTOT-1:NSAME] | next_conv[NTOT-1:NSAME])));
    end
  end

  // One wait state per access: waitrequest drops for one cycle, then rises again
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= READ_ZERO;
      selfIdx <= SELF_IDX_RESET;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        case (avs_address)
          REG_CTRL: avs_readdata <= {30'h0000_0000, selfIdx};
          REG_STATUS: avs_readdata <= {21'h00_0000, mode, 1'b0, inProcess,
                                       cliqueValid, failStop, failNone,
                                       failClique, failLocal, selfTestReq};
          REG_ACC: avs_readdata <= {25'h000_0000, acc};
          REG_CONV: avs_readdata <= {25'h000_0000, conv};
          REG_TRUST: avs_readdata <= {25'h000_0000, trust};
          REG_SUSP: avs_readdata <= {20'h0_0000, susp};
          default: avs_readdata <= READ_ZERO;
        endcase
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (busAccept && avs_write && avs_address == REG_CTRL) begin
        selfIdx <= avs_writedata[1:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  a_susp_cell_set:
    assert property ((mode != NFD_SELFTEST && errEvent.kind == NFD_EV_SUSP &&
                      errEvent.col < 2'(NOPP)) |=> susp[$past(errEvent.row)][$past(errEvent.col)])
    else $error("suspicion cell not set after path error");

  a_acc_hold_process:
    assert property ((!timing.procEnd && !timing.procStart && !timing.peCommEnd &&
                      !timing.localEnd) |=> acc == $past(acc))
    else $error("accusations changed outside a process boundary");

  a_between_deferred:
    assert property ((!inProcess && !timing.procStart && errEvent.kind == NFD_EV_SINGLE &&
                      errEvent.node < NODE_LIMIT && mode != NFD_SELFTEST)
                     ##1 (timing.procStart && timing.expectsInput && !timing.localEnd)
                     |=> acc[$past(errEvent.node, 2)])
    else $error("between-process accusation not applied at next input process");

  a_interval_clear:
    assert property ((timing.localEnd && !timing.procEnd && !timing.procStart &&
                      !timing.peCommEnd && errEvent.kind == NFD_EV_NONE)
                     |=> (acc == '0 && susp == '0))
    else $error("diagnostic interval end did not clear state");

  a_conv_hold:
    assert property ((!timing.collectiveEnd && !modeEntry) |=> $stable(conv))
    else $error("convictions changed outside collective interval end");

  a_conv_clear_entry:
    assert property ((mode == NFD_DETECT && $past(mode) != NFD_DETECT &&
                      !timing.collectiveEnd) |=> conv == '0)
    else $error("convictions not cleared entering detection");

  a_trust_outputs:
    assert property (##1 trusted == ~(accused | convicted))
    else $error("trusted set disagrees with accusations and convictions");

  a_selftest_request:
    assert property ((mode == NFD_PRESERVE && fault.localFail) |=> (abandon && selfTestReq))
    else $error("failure did not abandon activity and request self-test");

  a_selftest_quiet:
    assert property ((mode == NFD_SELFTEST && errEvent.kind != NFD_EV_NONE)
                     |=> (failLocal && !abandon))
    else $error("self-test error not attributed to local failure");

  a_clique_size:
    assert property (cliqueValid == ((|trusted[NSAME-1:0]) && (|trusted[NTOT-1:NSAME])))
    else $error("clique validity disagrees with trusted counts");

  a_during_pending:
    assert property ((inProcess && !timing.procEnd && mode != NFD_SELFTEST &&
                      errEvent.kind == NFD_EV_SINGLE && errEvent.node < NODE_LIMIT)
                     |=> pendDuring[$past(errEvent.node)])
    else $error("accusation raised during a process was not held pending");

  a_unexpected_target:
    assert property ((!inProcess && !timing.procStart && mode != NFD_SELFTEST &&
                      errEvent.kind == NFD_EV_UNEXPECTED && errEvent.col < 2'(NOPP))
                     |=> pendBetween[OPP_BASE + IDXW'($past(errEvent.col))])
    else $error("unexpected message did not accuse the opposite-kind sender");

  a_susp_eval:
    assert property ((timing.peCommEnd && !timing.localEnd)
                     |=> ((acc & $past(suspAcc)) == $past(suspAcc)))
    else $error("suspicion votes not applied at end of element communication");

  a_conv_load:
    assert property (timing.collectiveEnd |=> (conv == $past(convVote)))
    else $error("convictions not loaded from the ballot at collective end");

  a_selftest_susp:
    assert property ((mode == NFD_SELFTEST && !timing.localEnd) |=> $stable(susp))
    else $error("suspicions changed while in self-test");

  a_detect_none:
    assert property ((mode == NFD_DETECT && fault.noClique)
                     |=> (failNone && abandon))
    else $error("missing clique did not end detection");

  a_stop_clique:
    assert property (((mode == NFD_INIT || mode == NFD_JOIN || mode == NFD_PRESERVE) &&
                      fault.cliqueFail) |=> (failStop && abandon))
    else $error("clique failure did not trigger a fail-stop");
endmodule

// file: nfd_peer_model.sv
/*
  Behavioural model of the other bus nodes during collective diagnosis: each
  voter's accusation row and its input-check eligibility.
  Assumes the bench holds present high across the collective-end strobe.
*/
`timescale 1ns/1ps
module nfd_peer_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic present,
  input wire logic [nfd_pkg::NTOT-1:0] yesVoters,
  input wire logic [nfd_pkg::NTOT-1:0] defendants,
  input wire logic [nfd_pkg::NTOT-1:0] okVoters,
  output nfd_pkg::nfd_ballot_type voterAcc,
  output logic [nfd_pkg::NTOT-1:0] voterOk
);
  import nfd_pkg::*;
  // Outside a ballot the lines toggle, so a stale vote is never read as a fresh one
  always_ff @(posedge clk) begin
    if (reset) begin
      voterAcc <= '0;
      voterOk <= '0;
    end else if (present) begin
      for (int v = 0; v < NTOT; v++) begin
        voterAcc[v] <= defendants & {NTOT{yesVoters[v]}};
      end
      voterOk <= okVoters;
    end else begin
      voterAcc <= ~voterAcc;
      voterOk <= ~voterOk;
    end
  end
endmodule

// file: nfd_diag_test.sv
/*
  Self-checking bench for the node diagnosis block: strobes, ballots, register bus.
  Assumes the peer model answers ballots one cycle after present rises.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module nfd_diag_test;
  import nfd_pkg::*;
  localparam nfd_timing_type T_START = '{procStart:1'b1, default:1'b0};
  localparam nfd_timing_type T_STIN = '{procStart:1'b1, expectsInput:1'b1, default:1'b0};
  localparam nfd_timing_type T_END = '{procEnd:1'b1, default:1'b0};
  localparam nfd_timing_type T_PE = '{peCommEnd:1'b1, default:1'b0};
  localparam nfd_timing_type T_LOC = '{localEnd:1'b1, default:1'b0};
  localparam nfd_timing_type T_COL = '{collectiveEnd:1'b1, default:1'b0};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  nfd_mode_type mode = NFD_PRESERVE;
  nfd_error_type errEvent = '0;
  nfd_timing_type timing = '0;
  nfd_fault_type fault = '0;
  nfd_ballot_type voterAcc;
  logic [NTOT-1:0] voterOk, trusted, accused, convicted;
  logic [NTOT-1:0] yesVoters = '0, defendants = '0, okVoters = '0;
  logic present = 1'b0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic avs_waitrequest, cliqueValid, selfTestReq, abandon;
  int failures = 0;
  int cmpCount = 0;

  always #2.5 clk = ~clk;

  nfd_peer_model peer (.clk(clk), .reset(reset), .present(present), .yesVoters(yesVoters),
    .defendants(defendants), .okVoters(okVoters), .voterAcc(voterAcc), .voterOk(voterOk));
  nfd_diag dut (.clk(clk), .reset(reset), .ce(ce), .mode(mode), .errEvent(errEvent),
    .timing(timing), .fault(fault), .voterAcc(voterAcc), .voterOk(voterOk),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trusted(trusted), .accused(accused),
    .convicted(convicted), .cliqueValid(cliqueValid), .selfTestReq(selfTestReq),
    .abandon(abandon));

  task complete_run;
    $display("failures=%0d comparisons=%0d", failures, cmpCount);
    if (failures == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Waitrequest is read in the active region of the edge, i.e. its pre-edge value
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      complete_run;
    end
  endtask

  task tim(input nfd_timing_type t);
    @(posedge clk) timing <= t;
    @(posedge clk) timing <= '0;
  endtask

  task ev(input nfd_evkind_type k, input logic [2:0] n, input logic [1:0] r, c);
    @(posedge clk) errEvent <= '{kind:k, node:n, row:r, col:c};
    @(posedge clk) errEvent <= '0;
  endtask

  task t_reset_regs;
    #1;
    `CHK(trusted, 7'h7F);
    `CHK(accused, 7'h00);
    `CHK(cliqueValid, 1'b1);
    bus(1'b0, REG_TRUST, '0);
    `CHK(q, 32'h0000_007F);
    bus(1'b0, 5'h1C, '0);
    `CHK(q, 32'h0000_0000);
    bus(1'b1, REG_CTRL, 32'h0000_0003);
    bus(1'b1, REG_ACC, 32'h0000_007F);
    bus(1'b0, REG_ACC, '0);
    `CHK(q, 32'h0000_0000);
    bus(1'b0, REG_CTRL, '0);
    `CHK(q, 32'h0000_0003);
  endtask

  task t_during;
    tim(T_START);
    ev(NFD_EV_SINGLE, 3'h1, 2'h0, 2'h0);
    #1 `CHK(accused, 7'h00);
    tim(T_END);
    #1 `CHK(accused, 7'h02);
    `CHK(trusted, 7'h7D);
  endtask

  // While the enable is low a local interval end must not clear anything
  task t_freeze;
    @(posedge clk) ce <= 1'b0;
    tim(T_LOC);
    #1 `CHK(accused, 7'h02);
    @(posedge clk) ce <= 1'b1;
  endtask

  // Between-process error followed at once by an input-expecting process start
  task t_between;
    @(posedge clk) errEvent <= '{kind:NFD_EV_SINGLE, node:3'h5, row:2'h0, col:2'h0};
    @(posedge clk) begin
      errEvent <= '0;
      timing <= T_STIN;
    end
    @(posedge clk) timing <= '0;
    #1 `CHK(accused, 7'h20);
    tim(T_END);
    tim(T_LOC);
    #1 `CHK(accused, 7'h00);
  endtask

  // A process that expects no input must not release a between-process accusation
  task t_unexpected;
    ev(NFD_EV_UNEXPECTED, 3'h0, 2'h0, 2'h1);
    tim(T_START);
    tim(T_END);
    #1 `CHK(accused, 7'h02);
    tim(T_STIN);
    #1 `CHK(accused, 7'h22);
    tim(T_END);
    tim(T_LOC);
    #1 `CHK(accused, 7'h00);
  endtask

  // Row 0 distrusted leaves rows 1..3: two of three suspect column 0
  task t_susp;
    tim(T_START);
    ev(NFD_EV_SINGLE, 3'h0, 2'h0, 2'h0);
    ev(NFD_EV_SUSP, 3'h0, 2'h1, 2'h0);
    ev(NFD_EV_SUSP, 3'h0, 2'h2, 2'h0);
    tim(T_END);
    #1 `CHK(accused, 7'h01);
    bus(1'b0, REG_SUSP, '0);
    `CHK(q, 32'h0000_0048);
    tim(T_PE);
    #1 `CHK(accused, 7'h11);
    tim(T_LOC);
    bus(1'b0, REG_SUSP, '0);
    `CHK(q, 32'h0000_0000);
  endtask

  // Three yes out of five eligible convicts; counted over seven it would not
  task t_convict;
    @(posedge clk);
    present <= 1'b1;
    yesVoters <= 7'h07;
    defendants <= 7'h40;
    okVoters <= 7'h4F;
    tim(T_COL);
    #1 `CHK(convicted, 7'h40);
    `CHK(trusted, 7'h3F);
    tim(T_LOC);
    #1 `CHK(convicted, 7'h40);
    @(posedge clk) present <= 1'b0;
    mode <= NFD_DETECT;
    @(posedge clk);
    @(posedge clk);
    #1 `CHK(convicted, 7'h00);
  endtask

  task fail_case(input nfd_mode_type m, input nfd_fault_type f, input int pos);
    int hits;
    hits = 0;
    @(posedge clk) mode <= m;
    @(posedge clk) fault <= f;
    @(posedge clk) fault <= '0;
    repeat (4) begin
      #1;
      if (abandon === 1'b1) hits++;
      @(posedge clk);
    end
    `CHK(hits, 1);
    `CHK(selfTestReq, 1'b1);
    bus(1'b0, REG_STATUS, '0);
    `CHK(q[pos], 1'b1);
    bus(1'b1, REG_CTRL, 32'h0000_0103);
    #1 `CHK(selfTestReq, 1'b0);
  endtask

  task t_selftest;
    @(posedge clk) mode <= NFD_SELFTEST;
    ev(NFD_EV_SINGLE, 3'h2, 2'h0, 2'h0);
    #1 `CHK(accused, 7'h00);
    `CHK(abandon, 1'b0);
    bus(1'b0, REG_STATUS, '0);
    `CHK(q[1], 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_regs;
    t_during;
    t_freeze;
    t_unexpected;
    t_susp;
    t_between;
    t_convict;
    fail_case(NFD_DETECT, 3'h1, 3);
    fail_case(NFD_PRESERVE, 3'h4, 4);
    fail_case(NFD_JOIN, 3'h2, 4);
    fail_case(NFD_INIT, 3'h2, 4);
    t_selftest;
    complete_run;
  end
endmodule
